// File: bldc_pkg.sv
// Package of constants and carrier types for the sensorless commutator
`default_nettype none
package bldc_pkg;

    // Clock rate and derived cycle counts
    localparam int CLK_HZ = 10000000;
    localparam int NS_PER_CYCLE = 1000000000 / CLK_HZ;
    // Marker output low time, typical, in ns (range 4 to 10 us)
    localparam int MARKER_LOW_NS = 7000;
    localparam int MARKER_LOW_CYC = MARKER_LOW_NS / NS_PER_CYCLE;
    // Mux output low time after a marker sense, typical, in ns (range 5 to 15 us)
    localparam int MUX_LOW_NS = 7000;
    localparam int MUX_LOW_CYC = MUX_LOW_NS / NS_PER_CYCLE;
    localparam int PULSE_W = 8;
    localparam logic [PULSE_W-1:0] MARKER_LOW_CNT = PULSE_W'(MARKER_LOW_CYC);
    localparam logic [PULSE_W-1:0] MUX_LOW_CNT = PULSE_W'(MUX_LOW_CYC);

    // Counter widths and default terminal counts (stand-ins for the timing capacitors)
    localparam int CNT_W = 24;
    localparam int START_PERIOD_DEF = 5000000;
    localparam int WATCHDOG_DEF = 35000;
    localparam int DELAY_SHIFT_DEF = 1;

    // Commutation state encoding
    typedef enum logic [2:0] {ST1, ST2, ST3, ST4, ST5, ST6} comm_state_e;

    // One phase drive: enables active low, level when driven
    typedef struct packed {
        logic level;
        logic oe_n;
    } phase_drive_s;

    // Three-phase bundle
    typedef struct packed {
        phase_drive_s a;
        phase_drive_s b;
        phase_drive_s c;
    } phase_set_s;

    localparam phase_drive_s DRV_H = '{level: 1'b1, oe_n: 1'b0};
    localparam phase_drive_s DRV_L = '{level: 1'b0, oe_n: 1'b0};
    localparam phase_drive_s DRV_Z = '{level: 1'b0, oe_n: 1'b1};

endpackage
`default_nettype wire

// File: sensorless_bldc_commutator.sv
// Six-state sensorless BLDC commutation sequencer with tacho and marker outputs
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1: Each state drives two phases, one high one low, third floats.
// RULE2: States run Z/L/H, H/L/Z, H/Z/L, Z/H/L, L/H/Z, L/Z/H, then wrap.
// RULE3: Comparator of the currently floating phase is the active one.
// RULE4: Zero-crossing starts load-adaptive delay; commutate when it expires.
// RULE5: Every commutation restarts the start oscillator.
// RULE6: Start oscillator pulse advances the state without a zero-crossing.
// RULE7: Tacho runs at half commutation rate, 50 percent duty.
// RULE8: Mux output gives a low pulse after a marker sense, 5 to 15 us.
// RULE9: Separate active-low marker pulse, about 7 us, 4 to 10 us.
// RULE10: Mux output runs three full cycles per pole pair per revolution.
// RULE11: Every detected zero-crossing toggles the tacho output.
// RULE12: Watchdog after commutation flags failed recovery on wrong polarity.
// RULE13: Start period, delay scaling and watchdog are settable counts.
// RULE14: Reset gives state 1, start-up mode, tacho and marker high.
module sensorless_bldc_commutator #(
    parameter int CNT_W = bldc_pkg::CNT_W
) (
    input wire logic sys_clk, // System clock, 10 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [2:0] bemf_cmp, // Back-EMF comparators, bit0 phase a; 1 = above centre
    input wire logic marker_sense_in, // Marker sensor comparator output, high = pulse
    input wire logic [CNT_W-1:0] start_period_setting, // Start oscillator period in cycles
    input wire logic [CNT_W-1:0] watchdog_interval_setting, // Watchdog interval in cycles
    input wire logic [3:0] adaptive_delay_setting, // Delay = last period >> this
    output logic phase_out_a, // Phase a drive level
    output logic phase_out_a_oe_n, // Phase a output enable, low = driven
    output logic phase_out_b, // Phase b drive level
    output logic phase_out_b_oe_n, // Phase b output enable, low = driven
    output logic phase_out_c, // Phase c drive level
    output logic phase_out_c_oe_n, // Phase c output enable, low = driven
    output logic tacho_out, // Tacho, toggles per zero-crossing
    output logic tacho_marker_mux_out, // Tacho with marker low pulse merged
    output logic marker_out, // Marker pulse, active low
    output logic startup_mode, // High while running from the start oscillator
    output logic watchdog_fail // One-cycle pulse on failed recovery
);

    // =====================================================================
    // Decode functions
    // =====================================================================

    // Drive pattern of one state
    function automatic bldc_pkg::phase_set_s drive_of(input bldc_pkg::comm_state_e s);
        unique case (s)
            bldc_pkg::ST1: drive_of = '{bldc_pkg::DRV_Z, bldc_pkg::DRV_L, bldc_pkg::DRV_H};
            bldc_pkg::ST2: drive_of = '{bldc_pkg::DRV_H, bldc_pkg::DRV_L, bldc_pkg::DRV_Z};
            bldc_pkg::ST3: drive_of = '{bldc_pkg::DRV_H, bldc_pkg::DRV_Z, bldc_pkg::DRV_L};
            bldc_pkg::ST4: drive_of = '{bldc_pkg::DRV_Z, bldc_pkg::DRV_H, bldc_pkg::DRV_L};
            bldc_pkg::ST5: drive_of = '{bldc_pkg::DRV_L, bldc_pkg::DRV_H, bldc_pkg::DRV_Z};
            bldc_pkg::ST6: drive_of = '{bldc_pkg::DRV_L, bldc_pkg::DRV_Z, bldc_pkg::DRV_H};
            default: drive_of = '{bldc_pkg::DRV_Z, bldc_pkg::DRV_Z, bldc_pkg::DRV_Z};
        endcase
    endfunction
    // Floating phase index of one state, used to pick its comparator
    function automatic logic [1:0] float_of(input bldc_pkg::comm_state_e s);
        unique case (s)
            bldc_pkg::ST1, bldc_pkg::ST4: float_of = 2'h0;
            bldc_pkg::ST3, bldc_pkg::ST6: float_of = 2'h1;
            default: float_of = 2'h2;
        endcase
    endfunction

    // =====================================================================
    // Sequencer state and comparator selection
    // =====================================================================
    bldc_pkg::comm_state_e state;
    bldc_pkg::comm_state_e next_state;
    bldc_pkg::phase_set_s next_drive;
    logic sel_cmp;
    logic cmp_prev;
    logic expect_rise;
    logic zero_cross;
    logic commutate;
    logic start_pulse;
    logic delay_done;
    // Floating phase comparator; odd states see a falling EMF, even a rising one
    assign sel_cmp = bemf_cmp[float_of(state)]; // [RULE3]
    assign expect_rise = (state == bldc_pkg::ST2) || (state == bldc_pkg::ST4) ||
                         (state == bldc_pkg::ST6);
    assign zero_cross = (sel_cmp != cmp_prev) && (sel_cmp == expect_rise);
    assign commutate = delay_done || start_pulse; // [RULE4] [RULE6]
    assign next_state = (state == bldc_pkg::ST6) ? bldc_pkg::ST1 :
                        bldc_pkg::comm_state_e'(state + 3'h1);
    assign next_drive = drive_of(commutate ? next_state : state);

    // Advance on commutation and wrap after state six
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= bldc_pkg::ST1; // [RULE14]
        end else if (commutate) begin
            state <= next_state; // [RULE2]
        end
    end

    // Comparator history; reloaded on commutation so a new selection makes no edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp_prev <= 1'b0;
        end else if (commutate) begin
            cmp_prev <= ~expect_rise;
        end else begin
            cmp_prev <= sel_cmp;
        end
    end

    // Registered phase drivers track the state in the same cycle it changes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {phase_out_a, phase_out_a_oe_n} <= bldc_pkg::DRV_Z;
            {phase_out_b, phase_out_b_oe_n} <= bldc_pkg::DRV_Z;
            {phase_out_c, phase_out_c_oe_n} <= bldc_pkg::DRV_Z;
        end else begin
            {phase_out_a, phase_out_a_oe_n} <= next_drive.a; // [RULE1]
            {phase_out_b, phase_out_b_oe_n} <= next_drive.b; // [RULE1]
            {phase_out_c, phase_out_c_oe_n} <= next_drive.c; // [RULE1]
        end
    end

    // =====================================================================
    // Adaptive delay: the last full period between two commutations, shifted right by adaptive_delay_setting
    // =====================================================================
    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] last_period;
    logic [CNT_W-1:0] delay_cnt;
    logic delay_run;
    // Period measured between commutations; saturates at slow speed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            period_cnt <= '0;
            last_period <= '0;
        end else if (commutate) begin
            period_cnt <= '0;
            last_period <= period_cnt;
        end else if (period_cnt != '1) begin
            period_cnt <= period_cnt + 1'b1;
        end
    end

    // Delay armed by a zero-crossing; scaling stands in for the delay capacitor
    always_ff @(posedge sys_clk) begin
        if (rst || commutate) begin
            delay_run <= 1'b0;
            delay_cnt <= '0;
        end else if (zero_cross && !delay_run) begin
            delay_run <= 1'b1; // [RULE4]
            delay_cnt <= last_period >> adaptive_delay_setting; // [RULE13]
        end else if (delay_run && delay_cnt != '0) begin
            delay_cnt <= delay_cnt - 1'b1;
        end
    end
    assign delay_done = delay_run && (delay_cnt == '0);

    // =====================================================================
    // Start oscillator and start-up mode
    // =====================================================================
    logic [CNT_W-1:0] start_cnt;
    // Restarted by every commutation, so it only fires when no crossings come
    always_ff @(posedge sys_clk) begin
        if (rst || commutate) begin
            start_cnt <= '0; // [RULE5]
        end else begin
            start_cnt <= start_cnt + 1'b1;
        end
    end
    assign start_pulse = (start_cnt >= start_period_setting - 1'b1) && !delay_done; // [RULE13]

    // Start-up mode until a back-EMF driven commutation occurs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            startup_mode <= 1'b1; // [RULE14]
        end else if (start_pulse) begin
            startup_mode <= 1'b1;
        end else if (delay_done) begin
            startup_mode <= 1'b0;
        end
    end

    // =====================================================================
    // Watchdog on back-EMF recovery after each commutation
    // =====================================================================
    logic [CNT_W-1:0] wd_cnt;
    logic wd_run;
    // Runs while the selected EMF sits at the wrong polarity after commutation
    always_ff @(posedge sys_clk) begin
        if (rst || commutate) begin
            wd_run <= !rst;
            wd_cnt <= '0;
            watchdog_fail <= 1'b0;
        end else if (wd_run && sel_cmp != expect_rise) begin
            wd_cnt <= wd_cnt + 1'b1;
            watchdog_fail <= 1'b0;
            if (wd_cnt >= watchdog_interval_setting) begin
                wd_run <= 1'b0; // [RULE12]
                watchdog_fail <= 1'b1; // [RULE12]
            end
        end else begin
            wd_run <= 1'b0; // Recovered, or already expired
            watchdog_fail <= 1'b0;
        end
    end

    // =====================================================================
    // Tacho, marker and multiplexed outputs
    // =====================================================================
    logic [bldc_pkg::PULSE_W-1:0] marker_cnt;
    logic [bldc_pkg::PULSE_W-1:0] mux_cnt;
    logic marker_prev;
    logic marker_armed;
    // Tacho toggles on each zero-crossing: half commutation rate, even duty
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tacho_out <= 1'b1; // [RULE14]
        end else if (zero_cross) begin
            tacho_out <= ~tacho_out; // [RULE11] [RULE7]
        end
    end

    // Marker edge starts the marker pulse and arms selection of next tacho fall
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            marker_prev <= 1'b0;
            marker_cnt <= '0;
            marker_out <= 1'b1; // [RULE14]
        end else begin
            marker_prev <= marker_sense_in;
            if (marker_sense_in && !marker_prev) begin
                marker_cnt <= bldc_pkg::MARKER_LOW_CNT; // [RULE9]
                marker_out <= 1'b0;
            end else if (marker_cnt > 8'h01) begin
                marker_cnt <= marker_cnt - 8'h01;
            end else begin
                marker_cnt <= '0;
                marker_out <= 1'b1;
            end
        end
    end

    // Selected tacho fall gives a short low, then the line stays high for that half
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            marker_armed <= 1'b0;
            mux_cnt <= '0;
            tacho_marker_mux_out <= 1'b1; // [RULE14]
        end else begin
            if (marker_sense_in && !marker_prev) begin
                marker_armed <= 1'b1;
            end else if (zero_cross && tacho_out && marker_armed) begin
                marker_armed <= 1'b0;
            end
            if (zero_cross && tacho_out && marker_armed) begin
                mux_cnt <= bldc_pkg::MUX_LOW_CNT; // [RULE8]
                tacho_marker_mux_out <= 1'b0;
            end else if (mux_cnt > 8'h01) begin
                mux_cnt <= mux_cnt - 8'h01;
            end else if (mux_cnt == 8'h01) begin
                mux_cnt <= '0;
                tacho_marker_mux_out <= 1'b1;
            end else if (zero_cross) begin
                tacho_marker_mux_out <= ~tacho_out; // [RULE10]
            end
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    // The all-floating reset drive is still on the pins at the first edge after release
    one_floats_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
        !$past(rst) |->
        $countones({phase_out_a_oe_n, phase_out_b_oe_n, phase_out_c_oe_n}) == 1)
        else $error("not exactly one phase floating");
    state_wrap_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
        (commutate && state == bldc_pkg::ST6) |=> state == bldc_pkg::ST1)
        else $error("state did not wrap to one");
    start_step_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE6]
        start_pulse |=> state == $past(next_state))
        else $error("start pulse did not advance state");
    start_reset_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE5]
        commutate |=> start_cnt == '0)
        else $error("start oscillator not restarted");
    tacho_toggle_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE11]
        zero_cross |=> tacho_out != $past(tacho_out))
        else $error("tacho did not toggle on crossing");
    marker_width_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
        $fell(marker_out) |-> !marker_out [*8] ##0 (marker_out == 1'b0) ##1 1'b1)
        else $error("marker pulse too short");
    mux_width_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
        (zero_cross && tacho_out && marker_armed) |=> !tacho_marker_mux_out [*8])
        else $error("mux marker low too short");
    delay_commut_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE4]
        delay_done |=> startup_mode == 1'b0 && state == $past(next_state))
        else $error("delay expiry did not commutate");
endmodule // sensorless_bldc_commutator
`default_nettype wire

// File: bldc_motor_model.sv
// Behavioural winding model giving back-EMF comparator levels
`timescale 1ns/10ps
`default_nettype none
module bldc_motor_model #(
    parameter int DLY = 20
) (
    input wire logic sys_clk, // Commutator clock
    input wire logic en, // High = rotor turns
    input wire logic [2:0] oe_n, // Phase enables, low = driven
    input wire logic [2:0] lv, // Phase drive levels
    output logic [2:0] bemf // Comparator levels, bit0 phase a
);
    logic [2:0] oe_q = 3'h7;
    int cnt = 0;
    logic [2:0] nxt;
    // Crossing target of a floating winding is the next phase's drive
    assign nxt = {lv[0], lv[2], lv[1]};
    // Cycles since the floating winding last moved
    always @(posedge sys_clk) begin
        oe_q <= oe_n;
        cnt <= (oe_n != oe_q) ? 0 : cnt + 1;
    end
    // A stalled rotor stays on the wrong side, so the watchdog can see it
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            bemf[i] = oe_n[i] ? ((en && cnt >= DLY) ? nxt[i] : !nxt[i]) : lv[i];
        end
    end
endmodule // bldc_motor_model
`default_nettype wire

// File: sensorless_bldc_commutator_tb.sv
// Self-checking bench for the sensorless commutator
`timescale 1ns/10ps
`default_nettype none
module sensorless_bldc_commutator_tb;
    localparam int SP = 32'h0000_00c8; // Start period
    localparam int WD = 32'h0000_0028; // Watchdog interval
    localparam int DLY = 32'h0000_0014; // Model crossing delay
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic mark_in = 1'b0;
    logic en = 1'b0;
    logic [3:0] dly_shift = 4'h1; // Adaptive delay scaling, changed in mid-run
    wire [2:0] bemf;
    wire [2:0] oe_n;
    wire [2:0] lv;
    wire tacho, mux, marker, startup, wd_fail;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int wd_at = 0;
    int wd_cnt = 0;
    logic wd_seen = 1'b0;
    // Drive per state, index 0 is state 1: {oe_n cba, level cba}
    logic [5:0] exp_drv [6] = '{6'h0c, 6'h21, 6'h11, 6'h0a, 6'h22, 6'h14};

    always #50 sys_clk = ~sys_clk;

    // Cycle count and first watchdog report after each step
    always @(posedge sys_clk) begin
        cyc++;
        if (wd_fail === 1'b1) begin
            wd_cnt++;
            if (!wd_seen) wd_at = cyc;
            wd_seen = 1'b1;
        end
    end

    sensorless_bldc_commutator u_sensorless_bldc_commutator (
        .sys_clk(sys_clk), .rst(rst), .bemf_cmp(bemf), .marker_sense_in(mark_in),
        .start_period_setting(24'(SP)), .watchdog_interval_setting(24'(WD)),
        .adaptive_delay_setting(dly_shift),
        .phase_out_a(lv[0]), .phase_out_a_oe_n(oe_n[0]),
        .phase_out_b(lv[1]), .phase_out_b_oe_n(oe_n[1]),
        .phase_out_c(lv[2]), .phase_out_c_oe_n(oe_n[2]),
        .tacho_out(tacho), .tacho_marker_mux_out(mux), .marker_out(marker),
        .startup_mode(startup), .watchdog_fail(wd_fail));

    bldc_motor_model #(.DLY(DLY)) u_bldc_motor_model (
        .sys_clk(sys_clk), .en(en), .oe_n(oe_n), .lv(lv), .bemf(bemf));

    // ==========================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] expv);
        checks++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, expv, seen);
        end
    endtask

    // Waits, bounded, for the next change of phase drive
    task automatic wait_step;
        logic [5:0] old;
        int n;
        old = {oe_n, lv};
        n = 0;
        while ({oe_n, lv} === old && n < 1000) begin
            tick(1);
            n++;
        end
        wd_seen = 1'b0;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset;
        chk("rst_drive", {oe_n, lv}, 6'h38);
        chk("rst_outs", {tacho, mux, marker, startup, wd_fail}, 5'h1e);
        rst = 1'b0;
        tick(1);
        chk("state1", {oe_n, lv}, exp_drv[0]);
    endtask

    // Stalled rotor: start oscillator steps, watchdog reports each interval
    task automatic t_start;
        int tp;
        logic t0;
        t0 = tacho;
        tp = cyc;
        for (int k = 1; k <= 6; k++) begin
            wait_step();
            chk("start_drive", {oe_n, lv}, exp_drv[k % 6]);
            if (k > 1) begin
                chk("start_per", 16'(cyc - tp >= SP - 2 && cyc - tp <= SP + 2), 16'h1);
                chk("wd_time", 16'(wd_at - tp >= WD && wd_at - tp <= WD + 4), 16'h1);
            end
            tp = cyc;
        end
        chk("start_mode", startup, 1'b1);
        chk("tacho_idle", tacho, t0);
    endtask

    // Turning rotor: crossings drive commutation after the adaptive delay
    task automatic t_run;
        int tp;
        int tc;
        int pp;
        logic tq;
        en = 1'b1;
        wait_step();
        tp = cyc;
        pp = 0;
        wd_cnt = 0;
        for (int k = 0; k < 12; k++) begin
            tq = tacho;
            while (tacho === tq && cyc - tp < 300) tick(1);
            tc = cyc;
            chk("cross", 16'(tc - tp >= DLY && tc - tp <= DLY + 4), 16'h1);
            wait_step();
            if (k > 0) begin
                chk("delay", 16'(cyc - tc >= pp / 2 - 2 && cyc - tc <= pp / 2 + 3), 16'h1);
            end
            pp = cyc - tp;
            tp = cyc;
            chk("mux_follow", mux, tacho);
        end
        chk("run_mode", startup, 1'b0);
        chk("run_per", 16'(pp < SP), 16'h1);
        chk("wd_quiet", 16'(wd_cnt), 16'h0);
    endtask

    // Quarter scaling: delay after each crossing follows the last period over four
    task automatic t_scale;
        int tp;
        int tc;
        int pp;
        logic tq;
        dly_shift = 4'h2;
        wait_step();
        tp = cyc;
        pp = 0;
        for (int k = 0; k < 6; k++) begin
            tq = tacho;
            while (tacho === tq && cyc - tp < 300) tick(1);
            tc = cyc;
            wait_step();
            if (k > 0) begin
                chk("delay_q", 16'(cyc - tc >= pp / 4 - 2 && cyc - tc <= pp / 4 + 3), 16'h1);
            end
            pp = cyc - tp;
            tp = cyc;
        end
        chk("scale_mode", startup, 1'b0);
    endtask

    // Marker sense selects one tacho fall; both pulses measured together
    task automatic t_marker;
        int t0;
        int t1;
        mark_in = 1'b1;
        fork
            begin
                while (marker !== 1'b0 && cyc < t0 + 4) tick(1);
                mark_in = 1'b0;
                t0 = cyc;
                while (marker === 1'b0 && cyc - t0 < 200) tick(1);
                chk("mark_w", 16'(cyc - t0), 16'(bldc_pkg::MARKER_LOW_CYC));
            end
            begin
                while (mux !== 1'b0 && cyc < t1 + 300) tick(1);
                chk("mux_fall", tacho, 1'b0);
                t1 = cyc;
                while (mux === 1'b0 && cyc - t1 < 200) tick(1);
                chk("mux_w", 16'(cyc - t1), 16'(bldc_pkg::MUX_LOW_CYC));
            end
        join_none
        t0 = cyc;
        t1 = cyc;
        wait fork;
    endtask

    initial begin
        tick(16);
        t_reset();
        t_start();
        t_run();
        t_scale();
        t_marker();
        summarize();
    end

    // Cuts a hang short well beyond the expected run time
    initial begin
        #1000000;
        n_mismatch++;
        summarize();
    end
endmodule // sensorless_bldc_commutator_tb
`default_nettype wire
